/* logic/bsc_defs.svh */
// Constants for the boot select and code security block
// Summary of operation
// - Write 0x83, idle, wake: reset, run application
// - No strap condition: boot from application rom
// - Straps A,B low or C low: boot loader
// - Security register reachable only in programming mode
// - Programmed security bits stay zero until erase
// - Security register sits at loader top index
// - Lock zero refuses rom and security access
// - Inhibit zero: external code reads stay external
// - Internal code reads reach internal and external
// - Inhibit one: no code read restriction
// - Encryption on: port output passes encoder
// - Only whole erase clears encryption enable
// - Bit 7 zero selects half oscillator gain
// - Clock may stop; state is kept
// - Control bits 7,1,0 set: external-like reset
// - Loader flag reads one while loader runs
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
`define BSC_ADR_ISP   18'h0_0000
`define BSC_ADR_PRG   18'h0_0004
`define BSC_SEC_IDX   16'hffff
`define BSC_ADR_SEC   {`BSC_SEC_IDX, 2'b00}
`define BSC_ISP_SWRST 7
`define BSC_ISP_LDFLG 5
`define BSC_ISP_AUXR  4
`define BSC_ISP_FIXED 3
`define BSC_ISP_BTSL  1
`define BSC_ISP_PGEN  0
`define BSC_ISP_WMASK 8'h93
`define BSC_PRG_MODE  0
`define BSC_PRG_ERASE 1
`define BSC_SEC_LOCK  0
`define BSC_SEC_INH   1
`define BSC_SEC_ENC   2
`define BSC_SEC_OSC   7
`define BSC_SEC_ERASED 8'hff
`define BSC_ENC_KEY   8'h5a
// Strap filter settles on the fourth edge, so decide on the fifth
`define BSC_BOOT_WAIT 3'h4
`define BSC_SWRST_LEN 3'h4
`define BSC_CNT_ONE   3'h1
`endif

/* logic/bsc_pkg.sv */
// Types for the boot select and code security block
package bsc_pkg;
  typedef enum logic [1:0] {
    BSC_BOOT  = 2'b00,
    BSC_RUN   = 2'b01,
    BSC_SWRST = 2'b10
  } bsc_state_t;
endpackage : bsc_pkg

/* logic/bsc_top.sv */
// Boot source selection, software reset and code security logic
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "bsc_defs.svh"
module bsc_top (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [17:0] wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic             wb_ack,
  output logic      [31:0] wb_dat_r,
  input  wire logic        boot_strap_a,
  input  wire logic        boot_strap_b,
  input  wire logic        boot_strap_c,
  input  wire logic        cpu_idle,
  input  wire logic        timer_wake,
  output logic             cpu_rst,
  output logic             running_loader,
  output logic             aux_ram_en,
  output logic             rom_access_en,
  input  wire logic        ctr_req,
  input  wire logic        ctr_from_ext,
  input  wire logic        ctr_adr_int,
  output logic             ctr_int_sel,
  output logic             ctr_ext_sel,
  input  wire logic [7:0]  p0_raw,
  output logic      [7:0]  p0_coded,
  output logic             osc_half_gain
);
  import bsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Port encoder, also used by the checks
  function automatic logic [7:0] bsc_encode(input logic [7:0] d);
    logic [7:0] r;
    r = {d[4:0], d[7:5]};
    return r ^ `BSC_ENC_KEY;
  endfunction : bsc_encode

  ////////////////////////////////////////////////////////////////////////////
  // Strap synchronisers; a change counts once stages two and three agree
  logic [2:0] s1_reg, s2_reg, s3_reg;
  logic [2:0] strap_reg;
  logic [2:0] strap_next;

  always_comb
  begin
    strap_next = strap_reg;
    if (s2_reg == s3_reg)
    begin
      strap_next = s3_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_reg    <= 3'h7;
      s2_reg    <= 3'h7;
      s3_reg    <= 3'h7;
      strap_reg <= 3'h7;
    end
    else
    begin
      s1_reg    <= {boot_strap_c, boot_strap_b, boot_strap_a};
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      strap_reg <= strap_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control state
  bsc_state_t state_reg, state_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        rst_reg, rst_next;
  logic        ldr_reg, ldr_next;
  logic [7:0]  isp_reg, isp_next;
  logic        prg_reg, prg_next;
  logic        ack_reg, ack_next;
  logic [31:0] rd_reg, rd_next;
  logic        acc_reg, acc_next;
  logic        cint_reg, cint_next;
  logic        cext_reg, cext_next;
  logic [7:0]  p0_reg, p0_next;
  logic        half_reg, half_next;
  // Security bits model nonvolatile cells: no reset, only erase sets them
  logic [7:0]  sec_reg, sec_next;
  // Marks that an erase has given the cells known values; unknown before
  logic        known_reg, known_next;
  logic        acc, wr, sec_ok, armed, erase_w, int_ok, boot_ldr;

  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rst_next   = rst_reg;
    ldr_next   = ldr_reg;
    isp_next   = isp_reg;
    prg_next   = prg_reg;
    sec_next   = sec_reg;
    rd_next    = rd_reg;
    erase_w    = 1'b0;
    acc        = wb_cyc & wb_stb;
    ack_next   = acc & ~ack_reg;
    wr         = acc & ack_reg & wb_we & wb_sel[0];
    sec_ok     = prg_reg & sec_reg[`BSC_SEC_LOCK];
    armed      = isp_reg[`BSC_ISP_SWRST] & isp_reg[`BSC_ISP_BTSL]
               & isp_reg[`BSC_ISP_PGEN];
    boot_ldr   = (~strap_reg[0] & ~strap_reg[1]) | ~strap_reg[2];

    // Read data is latched together with ack
    if (acc & ~ack_reg)
    begin
      rd_next = 32'h0000_0000;
      if (wb_adr == `BSC_ADR_ISP)
      begin
        rd_next[7:0] = isp_reg;
        rd_next[`BSC_ISP_LDFLG] = ldr_reg;
        rd_next[`BSC_ISP_FIXED] = 1'b1;
      end
      else if (wb_adr == `BSC_ADR_PRG)
      begin
        rd_next[`BSC_PRG_MODE] = prg_reg;
      end
      else if (wb_adr == `BSC_ADR_SEC && sec_ok)
      begin
        rd_next[7:0] = sec_reg;
      end
    end

    // Writes take effect on the edge where ack is seen
    if (wr)
    begin
      if (wb_adr == `BSC_ADR_ISP && state_reg == BSC_RUN)
      begin
        isp_next = wb_dat_w[7:0] & `BSC_ISP_WMASK;
      end
      else if (wb_adr == `BSC_ADR_PRG)
      begin
        prg_next = wb_dat_w[`BSC_PRG_MODE];
        if (prg_reg & wb_dat_w[`BSC_PRG_ERASE])
        begin
          erase_w  = 1'b1;
          sec_next = `BSC_SEC_ERASED;
        end
      end
      else if (wb_adr == `BSC_ADR_SEC && sec_ok)
      begin
        sec_next = sec_reg & wb_dat_w[7:0];
      end
    end

    // Sequencer; purely edge driven, so a stopped clock just freezes it
    unique case (state_reg)
      BSC_BOOT:
      begin
        cnt_next = cnt_reg + `BSC_CNT_ONE;
        if (cnt_reg == `BSC_BOOT_WAIT)
        begin
          ldr_next   = boot_ldr;
          rst_next   = 1'b0;
          cnt_next   = 3'h0;
          state_next = BSC_RUN;
        end
      end
      BSC_RUN:
      begin
        // Armed reset waits for the timer wake-up if the core idles
        if (armed & (~cpu_idle | timer_wake))
        begin
          rst_next   = 1'b1;
          ldr_next   = 1'b0;
          isp_next   = 8'h00;
          cnt_next   = 3'h0;
          state_next = BSC_SWRST;
        end
        else if (isp_reg[`BSC_ISP_PGEN] & cpu_idle & timer_wake)
        begin
          ldr_next = 1'b1;
        end
      end
      BSC_SWRST:
      begin
        cnt_next = cnt_reg + `BSC_CNT_ONE;
        if (cnt_reg == `BSC_SWRST_LEN - `BSC_CNT_ONE)
        begin
          rst_next   = 1'b0;
          cnt_next   = 3'h0;
          state_next = BSC_RUN;
        end
      end
      default:
      begin
        state_next = BSC_BOOT;
        rst_next   = 1'b1;
        cnt_next   = 3'h0;
      end
    endcase

    // Protection outputs follow the security bits
    acc_next  = sec_reg[`BSC_SEC_LOCK];
    int_ok    = ctr_adr_int
              & ~(ctr_from_ext & ~sec_reg[`BSC_SEC_INH]);
    cint_next = ctr_req & int_ok;
    cext_next = ctr_req & ~int_ok;
    p0_next   = sec_reg[`BSC_SEC_ENC] ? p0_raw : bsc_encode(p0_raw);
    half_next = ~sec_reg[`BSC_SEC_OSC];
    known_next = known_reg | erase_w;
  end

  always_ff @(posedge clk)
  begin
    sec_reg   <= sec_next;
    known_reg <= known_next;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= BSC_BOOT;
      cnt_reg   <= 3'h0;
      rst_reg   <= 1'b1;
      ldr_reg   <= 1'b0;
      isp_reg   <= 8'h00;
      prg_reg   <= 1'b0;
      ack_reg   <= 1'b0;
      rd_reg    <= 32'h0000_0000;
      acc_reg   <= 1'b0;
      cint_reg  <= 1'b0;
      cext_reg  <= 1'b0;
      p0_reg    <= 8'h00;
      half_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      rst_reg   <= rst_next;
      ldr_reg   <= ldr_next;
      isp_reg   <= isp_next;
      prg_reg   <= prg_next;
      ack_reg   <= ack_next;
      rd_reg    <= rd_next;
      acc_reg   <= acc_next;
      cint_reg  <= cint_next;
      cext_reg  <= cext_next;
      p0_reg    <= p0_next;
      half_reg  <= half_next;
    end
  end

  assign wb_ack         = ack_reg;
  assign wb_dat_r       = rd_reg;
  assign cpu_rst        = rst_reg;
  assign running_loader = ldr_reg;
  assign aux_ram_en     = isp_reg[`BSC_ISP_AUXR];
  assign rom_access_en  = acc_reg;
  assign ctr_int_sel    = cint_reg;
  assign ctr_ext_sel    = cext_reg;
  assign p0_coded       = p0_reg;
  assign osc_half_gain  = half_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_swrst_restart: assert property (
    state_reg == BSC_RUN && armed && cpu_idle && timer_wake
    |=> cpu_rst && !running_loader ##3 cpu_rst ##1 !cpu_rst)
    else $error("software reset not issued or wrong length");

  chk_boot_app: assert property (
    state_reg == BSC_BOOT && cnt_reg == `BSC_BOOT_WAIT && strap_reg == 3'h7
    |=> !running_loader && !cpu_rst)
    else $error("boot did not start from application rom");

  chk_boot_ldr: assert property (
    state_reg == BSC_BOOT && cnt_reg == `BSC_BOOT_WAIT && boot_ldr
    |=> running_loader)
    else $error("strap reboot did not select loader rom");

  chk_sec_gate: assert property (
    acc && !ack_reg && wb_adr == `BSC_ADR_SEC && !prg_reg
    |=> wb_ack && wb_dat_r == 32'h0000_0000)
    else $error("security register read outside programming mode");

  chk_sec_mono: assert property (
    known_reg && !erase_w |=> (sec_reg & ~$past(sec_reg)) == 8'h00)
    else $error("security bit returned to one without erase");

  chk_lock_refuse: assert property (
    !sec_reg[`BSC_SEC_LOCK] |=> !rom_access_en ##1 !rom_access_en || sec_reg[0])
    else $error("rom access allowed while locked");

  chk_ctr_inhibit: assert property (
    ctr_req && ctr_from_ext && !sec_reg[`BSC_SEC_INH]
    |=> !ctr_int_sel && ctr_ext_sel)
    else $error("external code read reached internal rom");

  chk_ctr_internal: assert property (
    ctr_req && !ctr_from_ext && ctr_adr_int |=> ctr_int_sel)
    else $error("internal code read refused");

  chk_enc_path: assert property (
    !sec_reg[`BSC_SEC_ENC] |=> p0_coded == bsc_encode($past(p0_raw)))
    else $error("port data not encoded");

  chk_osc_gain: assert property (
    $fell(sec_reg[`BSC_SEC_OSC]) |=> osc_half_gain)
    else $error("half gain not selected");

  chk_ldflag_read: assert property (
    acc && !ack_reg && !wb_we && wb_adr == `BSC_ADR_ISP
    |=> wb_dat_r[`BSC_ISP_LDFLG] == $past(running_loader))
    else $error("loader flag misread");

  chk_erase_all: assert property (
    erase_w |=> sec_reg == `BSC_SEC_ERASED)
    else $error("erase-all left a security bit zero");

endmodule : bsc_top

/* tb/bsc_board_model.sv */
// Board strap switches with pull-ups
`timescale 1ns/1ps
module bsc_board_model (
  input  wire logic [2:0] press,
  output logic            boot_strap_a,
  output logic            boot_strap_b,
  output logic            boot_strap_c
);
  // Pull-ups hold straps inactive unless a switch is held
  assign boot_strap_a = ~press[0];
  assign boot_strap_b = ~press[1];
  assign boot_strap_c = ~press[2];
endmodule : bsc_board_model

/* tb/test_boot_select_and_code_security.sv */
// Self-checking bench of the boot select and code security block
`timescale 1ns/1ps
`include "bsc_defs.svh"
module test_boot_select_and_code_security;
  logic        clk, arst_n, wb_cyc, wb_stb, wb_we, wb_ack, cpu_idle, timer_wake;
  logic        cpu_rst, running_loader, rom_access_en, osc_half_gain, aux_ram_en;
  logic        ctr_req, ctr_from_ext, ctr_adr_int, ctr_int_sel, ctr_ext_sel;
  logic        boot_strap_a, boot_strap_b, boot_strap_c;
  logic [17:0] wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r, seed, q[$];
  logic [7:0]  p0_raw, p0_coded;
  logic [2:0]  press;
  int          fail_count, tests_run, cycles, i;
  bsc_board_model board (.press(press), .boot_strap_a(boot_strap_a),
    .boot_strap_b(boot_strap_b), .boot_strap_c(boot_strap_c));
  bsc_top dut (.clk(clk), .arst_n(arst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_ack(wb_ack),
    .wb_dat_r(wb_dat_r), .boot_strap_a(boot_strap_a), .boot_strap_b(boot_strap_b),
    .boot_strap_c(boot_strap_c), .cpu_idle(cpu_idle), .timer_wake(timer_wake),
    .cpu_rst(cpu_rst), .running_loader(running_loader), .aux_ram_en(aux_ram_en),
    .rom_access_en(rom_access_en), .ctr_req(ctr_req), .ctr_from_ext(ctr_from_ext),
    .ctr_adr_int(ctr_adr_int), .ctr_int_sel(ctr_int_sel), .ctr_ext_sel(ctr_ext_sel),
    .p0_raw(p0_raw), .p0_coded(p0_coded), .osc_half_gain(osc_half_gain));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Hang guard: whole run is a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      results();
    end
  end
  // Read data is compared against the oldest note when ack is seen
  always @(posedge clk)
    if (wb_ack === 1'b1 && wb_we === 1'b0)
      chk("wb_dat_r", q.size() ? q.pop_front() : 32'hdead_beef, wb_dat_r);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wb(input logic we, input logic [17:0] a, input logic [7:0] d,
                    input logic [7:0] e);
    @(posedge clk);
    wb_cyc   <= 1;
    wb_stb   <= 1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_dat_w <= {24'h0, d};
    if (!we)
      q.push_back({24'h0, e});
    do @(posedge clk); while (wb_ack !== 1'b1);
    wb_cyc <= 0;
    wb_stb <= 0;
  endtask : wb
  task automatic rst(input logic [2:0] sw);
    @(posedge clk);
    press  <= sw;
    arst_n <= 0;
    repeat (5) @(posedge clk);
    #1 chk("cpu_rst", 1, 32'(cpu_rst));
    arst_n <= 1;
    repeat (10) @(posedge clk);
    #1 chk("cpu_rst", 0, 32'(cpu_rst));
  endtask : rst
  task automatic p0(input logic en);
    @(posedge clk);
    seed = xs(seed);
    p0_raw <= seed[7:0];
    @(posedge clk);
    #1 chk("p0_coded", en ? {seed[4:0], seed[7:5]} ^ `BSC_ENC_KEY : seed[7:0], p0_coded);
  endtask : p0
  task automatic ctr(input logic [2:0] v, input logic inh0);
    logic hit;
    @(posedge clk);
    {ctr_req, ctr_from_ext, ctr_adr_int} <= v;
    hit = v[2] & v[0] & !(v[1] & inh0);
    @(posedge clk);
    #1 chk("ctr_int_sel", 32'(hit), 32'(ctr_int_sel));
    chk("ctr_ext_sel", 32'(v[2] & !hit), 32'(ctr_ext_sel));
  endtask : ctr
  task automatic pulse();
    @(posedge clk);
    timer_wake <= 1;
    @(posedge clk);
    timer_wake <= 0;
    #1;
  endtask : pulse
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {wb_cyc, wb_stb, wb_we, timer_wake, ctr_req, ctr_from_ext, ctr_adr_int} = 0;
    {wb_adr, wb_dat_w, cpu_idle, p0_raw, press, arst_n} = 0;
    wb_sel = 4'h1;
    seed = 32'h3d6a;
    rst(3'b000);
    chk("loader", 0, 32'(running_loader));
    wb(0, 18'h0_0008, 0, 0);
    wb(0, `BSC_ADR_ISP, 0, 8'h08);
    wb(0, `BSC_ADR_SEC, 0, 0);
    wb(1, `BSC_ADR_PRG, 8'h01, 0);
    wb(1, `BSC_ADR_PRG, 8'h03, 0);
    wb(0, `BSC_ADR_SEC, 0, 8'hff);
    #1 chk("gain", 0, 32'(osc_half_gain));
    chk("rom", 1, 32'(rom_access_en));
    p0(0);
    for (i = 0; i < 8; i++) ctr(i[2:0], 0);
    $display("test erase done");
    wb(1, `BSC_ADR_SEC, 8'h79, 0);
    wb(1, `BSC_ADR_SEC, 8'hff, 0);
    wb(0, `BSC_ADR_SEC, 0, 8'h79);
    #1 chk("gain", 1, 32'(osc_half_gain));
    p0(1);
    p0(1);
    for (i = 0; i < 8; i++) ctr(i[2:0], 1);
    $display("test protect done");
    wb(1, `BSC_ADR_PRG, 8'h00, 0);
    wb(1, `BSC_ADR_SEC, 8'h00, 0);
    wb(0, `BSC_ADR_SEC, 0, 0);
    wb(1, `BSC_ADR_PRG, 8'h01, 0);
    wb(0, `BSC_ADR_SEC, 0, 8'h79);
    wb(1, `BSC_ADR_SEC, 8'hfe, 0);
    @(posedge clk) #1 chk("rom", 0, 32'(rom_access_en));
    wb(0, `BSC_ADR_SEC, 0, 0);
    p0(1);
    wb(1, `BSC_ADR_PRG, 8'h03, 0);
    wb(0, `BSC_ADR_SEC, 0, 8'hff);
    p0(0);
    $display("test lock done");
    cpu_idle <= 1;
    wb(1, `BSC_ADR_ISP, 8'h11, 0);
    #1 chk("aux", 1, 32'(aux_ram_en));
    pulse();
    chk("loader", 1, 32'(running_loader));
    wb(0, `BSC_ADR_ISP, 0, 8'h39);
    wb(1, `BSC_ADR_ISP, 8'h83, 0);
    pulse();
    chk("cpu_rst", 1, 32'(cpu_rst));
    repeat (3) @(posedge clk) #1 chk("cpu_rst", 1, 32'(cpu_rst));
    @(posedge clk) #1 chk("cpu_rst", 0, 32'(cpu_rst));
    chk("loader", 0, 32'(running_loader));
    chk("aux", 0, 32'(aux_ram_en));
    cpu_idle <= 0;
    wb(0, `BSC_ADR_ISP, 0, 8'h08);
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      rst(i[2:0]);
      chk("loader", 32'((i[0] & i[1]) | i[2]), 32'(running_loader));
    end
    $display("test strap done");
    results();
  end
endmodule : test_boot_select_and_code_security
